// >>> csz_audio_src.sv
// Audio source model: DAC bit clock, frame clock and serial words
`timescale 1ns/100ps
module csz_audio_src (
  // Word control
  input  wire logic       l_zero,
  input  wire logic       r_zero,
  input  wire logic [5:0] half_bits,
  // Serial link
  output logic            dac_bit_clk,
  output logic            dac_frame_clk,
  output logic            dac_serial_in
);
  int b;
  initial
  begin
    dac_bit_clk = 1'b0;
    dac_frame_clk = 1'b0;
    dac_serial_in = 1'b0;
    forever
    begin
      for (b = 0; b < 2 * half_bits; b++)
      begin
        // Change on the falling edge so the rising edge sees settled data
        dac_frame_clk = (b < half_bits);
        // Ones sit mid-word, so a one-bit slot shift never leaks them
        dac_serial_in = ((b < half_bits) ? l_zero : r_zero) ? 1'b0 : ((b % half_bits) inside {[8:15]});
        #24 dac_bit_clk = 1'b1;
        #24 dac_bit_clk = 1'b0;
      end
    end
  end
endmodule // csz_audio_src

// >>> csz_consts.svh
// Constants for the codec sync, zero-flag and mode-control block
`ifndef CSZ_CONSTS_SVH
`define CSZ_CONSTS_SVH

`define CSZ_CLK_PERIOD_NS   100
`define CSZ_BCK64           20'd64
`define CSZ_BCK48           20'd48
`define CSZ_TRIP64_BCK      20'd6
`define CSZ_TRIP48_BCK      20'd5
`define CSZ_KEEP64_BCK      20'd5
`define CSZ_KEEP48_BCK      20'd4
`define CSZ_ZERO_RUN        1024
`define CSZ_RECOVER_FRAMES  64
`define CSZ_RATIO_HI        16'd256
`define CSZ_RATIO_MID       16'd192
`define CSZ_OSR_16          8'd16
`define CSZ_OSR_32          8'd32
`define CSZ_OSR_64          8'd64
`define CSZ_DEEMPH_44K      2'h0
`define CSZ_MODE_CAPTURE_AT 2'h2

`endif

// >>> csz_lock_mon.sv
// Frame-lock monitor: system clocks per frame against the held ratio
`timescale 1ns/100ps
`include "csz_consts.svh"
module csz_lock_mon import csz_pkg::*; #(
  parameter int CNT_W          = 16,
  parameter int RECOVER_FRAMES = `CSZ_RECOVER_FRAMES
) (
  // System clock
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             ce,
  // Synchronised frame clock and bit clock rate
  input  wire logic             frame_s,
  input  wire logic             bck_48,
  // Status
  output logic                  halt,
  output logic [CNT_W-1:0]      ratio_r
);
  csz_lock_state_type state_r;
  logic                 frame_d_r;
  logic [CNT_W-1:0]     cnt_r;
  logic [CNT_W-1:0]     good_r;
  logic                 fe;
  logic                 bad;
  logic                 over;

  function automatic logic [CNT_W-1:0] tol_of(input logic [CNT_W-1:0] r, input logic [19:0] nb, input logic b48);
    logic [19:0] p;
    p = ({{(20-CNT_W){1'b0}}, r} * nb) / (b48 ? `CSZ_BCK48 : `CSZ_BCK64);
    return p[CNT_W-1:0];
  endfunction

  function automatic logic [CNT_W-1:0] diff_of(input logic [CNT_W-1:0] a, input logic [CNT_W-1:0] b);
    return (a > b) ? a - b : b - a;
  endfunction

  assign fe   = frame_s & ~frame_d_r;
  // Drift beyond six (64 fs) or five (48 fs) bit clocks breaks lock
  assign bad  = diff_of(cnt_r, ratio_r)
                > tol_of(ratio_r, bck_48 ? `CSZ_TRIP48_BCK : `CSZ_TRIP64_BCK, bck_48);
  // A frame edge that never comes must not leave the path running
  assign over = cnt_r > ratio_r + tol_of(ratio_r, bck_48 ? `CSZ_TRIP48_BCK : `CSZ_TRIP64_BCK, bck_48);
  assign halt = (state_r != CSZ_LK_LOCKED);

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      frame_d_r <= 1'b0;
    else if (ce)
      frame_d_r <= frame_s;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      cnt_r <= '1;  // Saturated start: a cut first frame never becomes the reference
    else if (ce)
    begin
      if (fe)
        cnt_r <= CNT_W'(1);
      else if (cnt_r != {CNT_W{1'b1}})
        cnt_r <= cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_r <= CSZ_LK_ACQUIRE;
      ratio_r <= '0;
      good_r  <= '0;
    end
    else if (ce)
    begin
      case (state_r)
        CSZ_LK_ACQUIRE:
          if (fe)
          begin
            ratio_r <= cnt_r;
            good_r  <= '0;
            state_r <= CSZ_LK_RECOVER;
          end
        CSZ_LK_LOCKED:
          if (fe && bad)
          begin
            ratio_r <= cnt_r;
            good_r  <= '0;
            state_r <= CSZ_LK_RECOVER;
          end
          else if (over)
            state_r <= CSZ_LK_ACQUIRE;
        CSZ_LK_RECOVER:
          if (fe && bad)
          begin
            ratio_r <= cnt_r;
            good_r  <= '0;
          end
          else if (fe && good_r == CNT_W'(RECOVER_FRAMES - 1))
            state_r <= CSZ_LK_LOCKED;
          else if (fe)
            good_r <= good_r + 1'b1;
          else if (over)
            state_r <= CSZ_LK_ACQUIRE;
        default:
          state_r <= CSZ_LK_ACQUIRE;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_resynced;
    ce && fe && state_r == CSZ_LK_RECOVER && !bad && good_r == CNT_W'(RECOVER_FRAMES - 1);
  endsequence

  chk_drift_halt: assert property (ce && fe && state_r == CSZ_LK_LOCKED && bad
    |=> halt) else $error("drift beyond trip level did not halt");
  chk_small_drift: assert property (ce && fe && !over && state_r == CSZ_LK_LOCKED
    && diff_of(cnt_r, ratio_r) < tol_of(ratio_r, bck_48 ? `CSZ_KEEP48_BCK : `CSZ_KEEP64_BCK, bck_48)
    |=> !halt) else $error("small drift caused resync");
  chk_recover_end: assert property (s_resynced |=> !halt) else $error("path not released after recovery");
endmodule // csz_lock_mon

// >>> csz_pkg.sv
// Types shared by the codec sync, zero-flag and mode-control block
package csz_pkg;
  typedef enum logic [1:0] {
    CSZ_CTL_TWO_WIRE   = 2'b00,
    CSZ_CTL_PAR_DIFF   = 2'b01,
    CSZ_CTL_PAR_SINGLE = 2'b10,
    CSZ_CTL_THREE_WIRE = 2'b11
  } csz_ctl_mode_type;

  typedef enum logic [1:0] {
    CSZ_LK_ACQUIRE = 2'b00,
    CSZ_LK_RECOVER = 2'b01,
    CSZ_LK_LOCKED  = 2'b10
  } csz_lock_state_type;
endpackage

// >>> csz_top.sv
// Sync monitor, zero flags and mode-pin control of a stereo codec
// Function
// - DAC drift beyond 6/5 bit clocks halts DAC, holds mid-supply until recovered.
// - ADC drift beyond 6/5 bit clocks halts ADC, outputs zero until recovered.
// - Drift below 5/4 bit clocks never mutes or resyncs either path.
// - Stopped system clock freezes ADC data and DAC outputs.
// - ADC oversampling fixed 64 fs; DAC picks 64/32/16 fs from ratio.
// - Double-rate setting doubles the DAC oversampling rate in serial modes only.
// - Each DAC channel declares zero after 1024 consecutive zero samples.
// - Grouping 0 gives per-channel flags; 1 flags only when both zero.
// - Polarity 0 drives flags high on zero; 1 drives them low.
// - Mode pin: low two-wire, pulldown parallel diff, pullup parallel single, high three-wire.
// - Mode pin sampled only at reset; later changes ignored.
// - Shared pins serve three-wire, two-wire or parallel functions by mode.
// - Parallel role pin high makes ADC master at 256 fs; DAC stays slave.
// - Parallel format pin low gives 24-bit I2S, high left-justified.
// - Parallel de-emphasis pin high enables fixed 44.1 kHz de-emphasis.
// - Output is differential or single-ended; single-ended uses positive only.
// - Serial modes take all settings from serial register writes.
`timescale 1ns/100ps
`include "csz_consts.svh"
module csz_top import csz_pkg::*; #(
  parameter int CNT_W          = 16,
  parameter int RECOVER_FRAMES = `CSZ_RECOVER_FRAMES,
  parameter int ZERO_RUN       = `CSZ_ZERO_RUN
) (
  // System clock
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       ce,
  // DAC serial link
  input  wire logic       dac_bit_clk,
  input  wire logic       dac_frame_clk,
  input  wire logic       dac_serial_in,
  // ADC frame clock and bit clock rates
  input  wire logic       adc_frame_clk,
  input  wire logic       adc_bck_48,
  input  wire logic       dac_bck_48,
  // Four-state mode pin as sensed by the pad
  input  wire logic [1:0] mode_pin_state,
  // Shared control pins
  input  wire logic       shared_data_in,
  output logic            shared_data_out,
  output logic            shared_data_oe,
  input  wire logic       shared_clk_in,
  input  wire logic       shared_sel_in,
  // Towards the serial control port
  output logic            ctl_serial_data,
  output logic            ctl_serial_clk,
  output logic            ctl_select,
  output logic            three_wire_active,
  output logic            two_wire_active,
  input  wire logic       ser_data_pull_low,
  // Settings written through the serial control port
  input  wire logic       reg_adc_master,
  input  wire logic       reg_left_justified,
  input  wire logic       reg_deemph_en,
  input  wire logic [1:0] reg_deemph_rate,
  input  wire logic       reg_single_ended,
  input  wire logic       reg_double_rate,
  input  wire logic       flag_grouping_sel,
  input  wire logic       flag_polarity_sel,
  // Applied configuration
  output logic            adc_master,
  output logic            left_justified,
  output logic            deemph_en,
  output logic [1:0]      deemph_rate,
  output logic            out_single_ended,
  output logic            outp_en,
  output logic            outn_en,
  output logic [7:0]      dac_osr,
  output logic [7:0]      adc_osr,
  // Path control and flags
  output logic            mid_supply_level,
  output logic            adc_force_zero,
  output logic            left_zero_flag,
  output logic            right_zero_flag
);
  csz_ctl_mode_type ctl_mode_r;
  logic [1:0]       mode_s1_r;
  logic [1:0]       mode_s2_r;
  logic [1:0]       cap_cnt_r;
  logic             mode_cap_r;
  logic [2:0]       pin_s1_r;
  logic [2:0]       pin_s2_r;
  logic [1:0]       frm_s1_r;
  logic [1:0]       frm_s2_r;
  logic             adc_halt;
  logic             dac_halt;
  logic [CNT_W-1:0] dac_ratio;
  logic             parallel;
  logic             lj_nxt;
  // Link-domain state, then zero-flag sync and grouping in the system clock domain
  logic             ce_l1_r;
  logic             ce_l2_r;
  logic             lj_l1_r;
  logic             lj_l2_r;
  logic             frame_q_r;
  logic             frame_qq_r;
  logic             data_q_r;
  logic             left_now;
  logic             left_prev_r;
  logic             ones_r;
  logic             done_l;
  logic             zl_link;
  logic             zr_link;
  logic [1:0]       zf_s1_r;
  logic [1:0]       zf_s2_r;
  logic             zl_grp;
  logic             zr_grp;

  function automatic logic [7:0] osr_of(input logic [CNT_W-1:0] ratio, input logic dbl);
    logic [7:0] base;
    if (ratio >= `CSZ_RATIO_HI)
      base = `CSZ_OSR_64;
    else if (ratio >= `CSZ_RATIO_MID)
      base = `CSZ_OSR_32;
    else
      base = `CSZ_OSR_16;
    return dbl ? {base[6:0], 1'b0} : base;
  endfunction

  // Pin and zero-flag synchronisers
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      mode_s1_r <= 2'h0;
      mode_s2_r <= 2'h0;
      pin_s1_r  <= 3'h0;
      pin_s2_r  <= 3'h0;
      frm_s1_r  <= 2'h0;
      frm_s2_r  <= 2'h0;
      zf_s1_r   <= 2'h0;
      zf_s2_r   <= 2'h0;
    end
    else if (ce)
    begin
      mode_s1_r <= mode_pin_state;
      mode_s2_r <= mode_s1_r;
      pin_s1_r  <= {shared_sel_in, shared_clk_in, shared_data_in};
      pin_s2_r  <= pin_s1_r;
      frm_s1_r  <= {dac_frame_clk, adc_frame_clk};
      frm_s2_r  <= frm_s1_r;
      zf_s1_r   <= {zr_link, zl_link};
      zf_s2_r   <= zf_s1_r;
    end
  end

  // Mode pin is caught once the synchroniser has filled after reset release
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cap_cnt_r  <= 2'h0;
      mode_cap_r <= 1'b0;
      ctl_mode_r <= CSZ_CTL_TWO_WIRE;
    end
    else if (ce && !mode_cap_r)
    begin
      cap_cnt_r <= cap_cnt_r + 2'h1;
      if (cap_cnt_r == `CSZ_MODE_CAPTURE_AT)
      begin
        ctl_mode_r <= csz_ctl_mode_type'(mode_s2_r);
        mode_cap_r <= 1'b1;
      end
    end
  end

  assign parallel = (ctl_mode_r == CSZ_CTL_PAR_DIFF) || (ctl_mode_r == CSZ_CTL_PAR_SINGLE);
  assign lj_nxt   = parallel ? pin_s2_r[1] : reg_left_justified;

  // Shared pin routing; two-wire data is open drain
  always_comb
  begin
    three_wire_active = mode_cap_r && (ctl_mode_r == CSZ_CTL_THREE_WIRE);
    two_wire_active   = mode_cap_r && (ctl_mode_r == CSZ_CTL_TWO_WIRE);
    ctl_serial_data   = (three_wire_active || two_wire_active) ? shared_data_in : 1'b1;
    ctl_serial_clk    = (three_wire_active || two_wire_active) ? shared_clk_in : 1'b1;
    ctl_select        = (three_wire_active || two_wire_active) ? shared_sel_in : 1'b1;
    shared_data_out   = 1'b0;
    shared_data_oe    = two_wire_active && ser_data_pull_low;
  end

  // Applied configuration
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      adc_master       <= 1'b0;
      left_justified   <= 1'b0;
      deemph_en        <= 1'b0;
      deemph_rate      <= `CSZ_DEEMPH_44K;
      out_single_ended <= 1'b0;
      outp_en          <= 1'b0;
      outn_en          <= 1'b0;
    end
    else if (ce)
    begin
      if (parallel)
      begin
        adc_master       <= pin_s2_r[2];
        left_justified   <= lj_nxt;
        deemph_en        <= pin_s2_r[0];
        deemph_rate      <= `CSZ_DEEMPH_44K;
        out_single_ended <= (ctl_mode_r == CSZ_CTL_PAR_SINGLE);
        outp_en          <= 1'b1;
        outn_en          <= (ctl_mode_r != CSZ_CTL_PAR_SINGLE);
      end
      else
      begin
        adc_master       <= reg_adc_master;
        left_justified   <= lj_nxt;
        deemph_en        <= reg_deemph_en;
        deemph_rate      <= reg_deemph_rate;
        out_single_ended <= reg_single_ended;
        outp_en          <= 1'b1;
        outn_en          <= !reg_single_ended;
      end
    end
  end

  csz_lock_mon #(
    .CNT_W          (CNT_W),
    .RECOVER_FRAMES (RECOVER_FRAMES)
  ) u_adc_lock (
    .clk     (clk),
    .reset   (reset),
    .ce      (ce),
    .frame_s (frm_s2_r[0]),
    .bck_48  (adc_bck_48),
    .halt    (adc_halt),
    .ratio_r ()
  );

  csz_lock_mon #(
    .CNT_W          (CNT_W),
    .RECOVER_FRAMES (RECOVER_FRAMES)
  ) u_dac_lock (
    .clk     (clk),
    .reset   (reset),
    .ce      (ce),
    .frame_s (frm_s2_r[1]),
    .bck_48  (dac_bck_48),
    .halt    (dac_halt),
    .ratio_r (dac_ratio)
  );

  // Freezing on ce low keeps the last output state when the system clock stops
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      mid_supply_level <= 1'b1;
      adc_force_zero   <= 1'b1;
      dac_osr          <= `CSZ_OSR_64;
      adc_osr          <= `CSZ_OSR_64;
    end
    else if (ce)
    begin
      mid_supply_level <= dac_halt;
      adc_force_zero   <= adc_halt;
      dac_osr          <= osr_of(dac_ratio, reg_double_rate && !parallel);
      adc_osr          <= `CSZ_OSR_64;
    end
  end

  // Link domain: the clock enable and format cross by two flip-flops
  always_ff @(posedge dac_bit_clk or posedge reset)
  begin
    if (reset)
    begin
      ce_l1_r <= 1'b0;
      ce_l2_r <= 1'b0;
      lj_l1_r <= 1'b0;
      lj_l2_r <= 1'b0;
    end
    else
    begin
      ce_l1_r <= ce;
      ce_l2_r <= ce_l1_r;
      lj_l1_r <= left_justified;
      lj_l2_r <= lj_l1_r;
    end
  end

  // I2S data trails the frame edge by one bit, so its channel uses the later frame copy
  assign left_now = lj_l2_r ? frame_q_r : !frame_qq_r;
  assign done_l   = ce_l2_r && (left_now != left_prev_r);

  always_ff @(posedge dac_bit_clk or posedge reset)
  begin
    if (reset)
    begin
      frame_q_r   <= 1'b0;
      frame_qq_r  <= 1'b0;
      data_q_r    <= 1'b0;
      left_prev_r <= 1'b0;
      ones_r      <= 1'b0;
    end
    else if (ce_l2_r)
    begin
      frame_q_r   <= dac_frame_clk;
      frame_qq_r  <= frame_q_r;
      data_q_r    <= dac_serial_in;
      left_prev_r <= left_now;
      if (left_now != left_prev_r)
        ones_r <= data_q_r;
      else
        ones_r <= ones_r | data_q_r;
    end
  end

  csz_zero_det #(
    .ZERO_RUN (ZERO_RUN)
  ) u_zero_left (
    .link_clk  (dac_bit_clk),
    .reset     (reset),
    .run_en    (ce_l2_r),
    .word_done (done_l && left_prev_r),
    .word_zero (!ones_r),
    .zero_r    (zl_link)
  );

  csz_zero_det #(
    .ZERO_RUN (ZERO_RUN)
  ) u_zero_right (
    .link_clk  (dac_bit_clk),
    .reset     (reset),
    .run_en    (ce_l2_r),
    .word_done (done_l && !left_prev_r),
    .word_zero (!ones_r),
    .zero_r    (zr_link)
  );

  assign zl_grp = flag_grouping_sel ? (zf_s2_r[0] && zf_s2_r[1]) : zf_s2_r[0];
  assign zr_grp = flag_grouping_sel ? (zf_s2_r[0] && zf_s2_r[1]) : zf_s2_r[1];

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      left_zero_flag  <= 1'b0;
      right_zero_flag <= 1'b0;
    end
    else if (ce)
    begin
      left_zero_flag  <= zl_grp ^ flag_polarity_sel;
      right_zero_flag <= zr_grp ^ flag_polarity_sel;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_mode_pin_hold: assert property (mode_cap_r |=> $stable(ctl_mode_r))
    else $error("control mode changed after capture");
  chk_single_pos_only: assert property (ce && out_single_ended |-> outp_en && !outn_en)
    else $error("negative output enabled in single-ended mode");
  chk_flag_group: assert property (ce && flag_grouping_sel && !flag_polarity_sel
    |=> left_zero_flag == right_zero_flag) else $error("grouped flags disagree");
  chk_adc_zero_follow: assert property (ce |=> adc_force_zero == $past(adc_halt))
    else $error("ADC zero forcing does not follow lock loss");
endmodule // csz_top

// >>> csz_zero_det.sv
// Per-channel run counter of zero samples, in the DAC bit clock domain
`timescale 1ns/100ps
`include "csz_consts.svh"
module csz_zero_det import csz_pkg::*; #(
  parameter int ZERO_RUN = `CSZ_ZERO_RUN
) (
  // Link clock and reset
  input  wire logic link_clk,
  input  wire logic reset,
  input  wire logic run_en,
  // Completed sample
  input  wire logic word_done,
  input  wire logic word_zero,
  // Zero condition
  output logic      zero_r
);
  logic [$clog2(ZERO_RUN+1)-1:0] run_r;

  always_ff @(posedge link_clk or posedge reset)
  begin
    if (reset)
    begin
      run_r  <= '0;
      zero_r <= 1'b0;
    end
    else if (run_en && word_done)
    begin
      if (!word_zero)
      begin
        run_r  <= '0;
        zero_r <= 1'b0;
      end
      else if (run_r != ($bits(run_r))'(ZERO_RUN))
      begin
        run_r  <= run_r + 1'b1;
        zero_r <= (run_r == ($bits(run_r))'(ZERO_RUN - 1));
      end
    end
  end

  default clocking cb @(posedge link_clk); endclocking
  default disable iff (reset);

  chk_zero_run_set: assert property (run_en && word_done && word_zero && run_r == ($bits(run_r))'(ZERO_RUN - 1)
    |=> zero_r) else $error("zero condition missed after full run");
  chk_zero_clear: assert property (run_en && word_done && !word_zero
    |=> !zero_r ##1 !zero_r) else $error("zero condition kept after nonzero sample");
endmodule // csz_zero_det

// >>> test_codec_sync_zero_mode_control.sv
// Self-checking bench for the codec sync, zero-flag and mode-control block
`timescale 1ns/100ps
module test_codec_sync_zero_mode_control;
  logic clk, reset, ce, l_zero, r_zero, dac_bit_clk, dac_frame_clk, dac_serial_in;
  logic adc_bck_48, dac_bck_48, shared_data_in, shared_clk_in, shared_sel_in, ser_data_pull_low;
  logic reg_adc_master, reg_left_justified, reg_deemph_en, reg_single_ended, reg_double_rate;
  logic flag_grouping_sel, flag_polarity_sel, shared_data_out, shared_data_oe, ctl_serial_data;
  logic ctl_serial_clk, ctl_select, three_wire_active, two_wire_active, adc_master, left_justified;
  logic deemph_en, out_single_ended, outp_en, outn_en, mid_supply_level, adc_force_zero;
  logic left_zero_flag, right_zero_flag, ser, hit;
  logic [1:0] mode_pin_state, reg_deemph_rate, deemph_rate, rnd;
  logic [5:0] half_bits;
  logic [7:0] dac_osr, adc_osr;
  wire        adc_frame_clk = dac_frame_clk;
  int         n_fail = 0, num_checks = 0, cyc = 0, seed = 32'hbe3f, k;

  csz_top #(.RECOVER_FRAMES(4), .ZERO_RUN(8)) csz_top_i (.clk, .reset, .ce, .dac_bit_clk,
    .dac_frame_clk, .dac_serial_in, .adc_frame_clk, .adc_bck_48, .dac_bck_48, .mode_pin_state,
    .shared_data_in, .shared_data_out, .shared_data_oe, .shared_clk_in, .shared_sel_in,
    .ctl_serial_data, .ctl_serial_clk, .ctl_select, .three_wire_active, .two_wire_active,
    .ser_data_pull_low, .reg_adc_master, .reg_left_justified, .reg_deemph_en, .reg_deemph_rate,
    .reg_single_ended, .reg_double_rate, .flag_grouping_sel, .flag_polarity_sel, .adc_master,
    .left_justified, .deemph_en, .deemph_rate, .out_single_ended, .outp_en, .outn_en, .dac_osr,
    .adc_osr, .mid_supply_level, .adc_force_zero, .left_zero_flag, .right_zero_flag);
  csz_audio_src csz_audio_src_i (.l_zero, .r_zero, .half_bits, .dac_bit_clk, .dac_frame_clk,
    .dac_serial_in);

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_vec(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic exp_flag(input logic a, input logic b, input logic g, input logic p);
    return (g ? a & b : a) ^ p;
  endfunction

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic wait_mid(input logic v, input int lim);
    int n;
    n = 0;
    while (mid_supply_level !== v && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    chk_bit(mid_supply_level, v);
    repeat (4) @(negedge clk);
  endtask

  task automatic do_reset(input logic [1:0] m);
    @(posedge clk);
    reset <= 1'b1;
    mode_pin_state <= m;
    @(negedge clk);
    chk_bit(mid_supply_level, 1'b1);
    chk_bit(adc_force_zero, 1'b1);
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask

  // Cuts a hang short; the whole run needs well under a third of this
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_fail++;
      stop_test();
    end
  end

  initial
  begin
    {reset, ce, l_zero, r_zero, flag_grouping_sel, flag_polarity_sel} = 6'h30;
    {adc_bck_48, dac_bck_48, shared_data_in, shared_clk_in, shared_sel_in} = 5'h0;
    {ser_data_pull_low, reg_adc_master, reg_left_justified, reg_deemph_en} = 4'h0;
    {reg_single_ended, reg_double_rate, mode_pin_state, reg_deemph_rate} = 6'h0;
    half_bits = 6'd32;
    for (k = 0; k < 4; k++)
    begin
      @(posedge clk);
      {shared_data_in, shared_clk_in, shared_sel_in, reg_adc_master, reg_left_justified} <= 5'($random(seed));
      {reg_deemph_en, reg_single_ended, reg_double_rate, ser_data_pull_low} <= 4'($random(seed));
      reg_deemph_rate <= 2'($random(seed));
      do_reset(2'(k));
      ser = (k == 0 || k == 3);
      chk_bit(three_wire_active, k == 3);
      chk_bit(two_wire_active, k == 0);
      chk_bit(ctl_select, ser ? shared_sel_in : 1'b1);
      chk_bit(ctl_serial_clk, ser ? shared_clk_in : 1'b1);
      chk_bit(ctl_serial_data, ser ? shared_data_in : 1'b1);
      chk_bit(shared_data_out, 1'b0);
      chk_bit(outp_en, 1'b1);
      chk_bit(shared_data_oe, k == 0 && ser_data_pull_low);
      chk_bit(adc_master, ser ? reg_adc_master : shared_sel_in);
      chk_bit(left_justified, ser ? reg_left_justified : shared_clk_in);
      chk_bit(deemph_en, ser ? reg_deemph_en : shared_data_in);
      chk_vec(8'(deemph_rate), ser ? 8'(reg_deemph_rate) : 8'h0);
      chk_bit(out_single_ended, ser ? reg_single_ended : k == 2);
      chk_bit(outn_en, !(ser ? reg_single_ended : k == 2));
      chk_vec(adc_osr, 8'h40);
      @(posedge clk);
      mode_pin_state <= ~mode_pin_state;
      repeat (8) @(posedge clk);
      @(negedge clk);
      chk_bit(three_wire_active, k == 3);
      chk_bit(two_wire_active, k == 0);
      wait_mid(1'b0, 1500);
      chk_bit(adc_force_zero, 1'b0);
      chk_vec(dac_osr, (ser && reg_double_rate) ? 8'h20 : 8'h10);
      $display("test mode %0d done", k);
    end
    @(posedge clk);
    shared_clk_in <= 1'b1;
    // 48 fs bit clock from here on, then a two-bit-clock drift that must not mute
    {adc_bck_48, dac_bck_48, half_bits} <= {2'h3, 6'd24};
    do_reset(2'h1);
    wait_mid(1'b0, 1500);
    @(posedge clk);
    half_bits <= 6'd25;
    hit = 1'b0;
    repeat (600)
    begin
      @(negedge clk);
      hit = hit | mid_supply_level | adc_force_zero;
    end
    chk_bit(hit, 1'b0);
    @(posedge clk);
    half_bits <= 6'd40;
    wait_mid(1'b1, 100);
    chk_bit(mid_supply_level, 1'b1);
    chk_bit(adc_force_zero, 1'b1);
    repeat (90) @(negedge clk);
    chk_bit(mid_supply_level, 1'b1);
    wait_mid(1'b0, 600);
    chk_bit(mid_supply_level, 1'b0);
    chk_bit(adc_force_zero, 1'b0);
    $display("test lock done");
    rnd = 2'($random(seed));
    for (k = 0; k < 4; k++)
    begin
      @(posedge clk);
      {l_zero, r_zero} <= ~2'(k);
      {flag_grouping_sel, flag_polarity_sel} <= 2'(k) + rnd;
      repeat (500) @(posedge clk);
      @(negedge clk);
      chk_bit(left_zero_flag, exp_flag(l_zero, r_zero, flag_grouping_sel, flag_polarity_sel));
      chk_bit(right_zero_flag, exp_flag(r_zero, l_zero, flag_grouping_sel, flag_polarity_sel));
    end
    @(posedge clk);
    {l_zero, r_zero} <= 2'h3;
    repeat (150) @(negedge clk);
    chk_bit(left_zero_flag, flag_polarity_sel);
    repeat (400) @(posedge clk);
    ce <= 1'b0;
    l_zero <= 1'b0;
    repeat (600) @(negedge clk);
    chk_bit(left_zero_flag, ~flag_polarity_sel);
    chk_bit(mid_supply_level, 1'b0);
    $display("test zero flags done");
    stop_test();
  end
endmodule // test_codec_sync_zero_mode_control
